// file: core/dlpc_top.v
// delay line phase controller: register file, search and track engine, status flags
`timescale 1ns/1ps
`default_nettype none
`include "dlpc_regs.vh"
// ============================================================
// Functional notes
// RL1: software writes ones to phase detector enable and comparator boost; both reset zero
// RL2: software sets duty cycle enable bit seven; it resets zero
// RL3: slope bit six picks negative or positive slope; resets to one
// RL4: mode field selects search-and-track, search only, or track only
// RL5: readback bit three shows current delay value in delay registers
// RL6: gain field bits two to one sets tracking loop gain; resets 01
// RL7: enable bit zero turns controller on; disabled after reset
// RL8: nine-bit delay value: lsb at 0x27 bit 7, rest at 0x28
// RL9: when disabled the delay line follows the written delay value
// RL10: when enabled the written delay value is the search start
// RL11: readback gives written value if disabled, locked value if enabled
// RL12: search direction field picks down, up, or down then up
// RL13: five-bit target phase field sets the phase sought
// RL14: tolerance bit zero accepts within two codes, one requires exact
// RL15: failed search stops if retry is zero, searches again if one
// RL16: failed search continues or resets controller per reset-on-failure bit
// RL17: guard band at both line ends avoided unless no valid phase outside
// RL18: lost-lock flag at status bit one
// RL19: locked flag at status bit zero
// RL20: controller runs a delay-locked loop and tracks alignment
// RL21: interrupt output asserted when controller falls out of lock
// RL22: reaching target in search-and-track sets locked and starts tracking
// RL23: lost-lock flag sticky until controller disabled and re-enabled
module dlpc_top #(
    parameter DW = 9
) (
    input  wire          core_clk,
    input  wire          reset_n,
    input  wire          clkEn,
    input  wire          regWrEn,
    input  wire          regRdEn,
    input  wire [7:0]    regAddr,
    input  wire [7:0]    regWrData,
    output reg  [7:0]    regRdData,
    input  wire [4:0]    phaseIn,
    output reg  [DW-1:0] delayLine,
    output reg           lockIrq
);
    localparam ST_IDLE   = 3'h0;
    localparam ST_SEARCH = 3'h1;
    localparam ST_SETTLE = 3'h2;
    localparam ST_TRACK  = 3'h3;
    localparam ST_FAIL   = 3'h4;
    localparam ST_HOLD   = 3'h5;

    // ============================================================
    // configuration registers, engine state and decoded fields
    reg [7:0]    pdSetup_r;
    reg [7:0]    dutySetup_r;
    reg [7:0]    loopCtrl_r;
    reg [7:0]    searchTgt_r;
    reg [7:0]    delayUpper_r;
    reg [7:0]    policy_r;
    reg [4:0]    phaseSync1_r;
    reg [4:0]    phaseSync2_r;
    reg [2:0]    state_r;
    reg [DW-1:0] cur_r;
    reg [DW-1:0] lockedVal_r;
    reg          locked_r;
    reg          lostLock_r;
    reg          dirUp_r;
    reg          guardOff_r;
    reg          secondPass_r;
    reg [7:0]    settle_r;
    reg          enPrev_r;
    reg [2:0]    shAddr_r;
    wire [7:0]   shData;

    wire          wrHit      = clkEn & regWrEn;
    wire          ctrlEn     = loopCtrl_r[`DLPC_BIT_ENABLE];          // [RL7]
    wire [1:0]    mode       = loopCtrl_r[5:4];
    wire [1:0]    gain       = loopCtrl_r[2:1];
    wire          slopePos   = loopCtrl_r[`DLPC_BIT_SLOPE];
    wire          readback   = loopCtrl_r[`DLPC_BIT_READBACK];
    wire [1:0]    searchDir  = searchTgt_r[6:5];
    wire [4:0]    target     = searchTgt_r[4:0];                       // [RL13]
    wire [4:0]    guard      = policy_r[4:0];
    wire [DW-1:0] progDelay  = {delayUpper_r, searchTgt_r[`DLPC_BIT_DELAY_LSB]}; // [RL8]
    wire [4:0]    phase      = phaseSync2_r;

    // ============================================================
    // helpers
    function [4:0] absDiff;
        input [4:0] a;
        input [4:0] b;
        begin
            absDiff = (a > b) ? a - b : b - a;
        end
    endfunction

    function phaseOk;
        input [4:0] ph;
        input [4:0] tg;
        input       exact;
        begin
            phaseOk = exact ? (ph == tg) : (absDiff(ph, tg) <= 5'h2); // [RL14]
        end
    endfunction

    function [DW-1:0] lowBound;
        input [4:0] g;
        input       off;
        begin
            lowBound = off ? {DW{1'b0}} : {{(DW-5){1'b0}}, g};        // [RL17]
        end
    endfunction

    function [DW-1:0] highBound;
        input [4:0] g;
        input       off;
        begin
            highBound = off ? `DLPC_DELAY_MAX : `DLPC_DELAY_MAX - {{(DW-5){1'b0}}, g}; // [RL17]
        end
    endfunction

    wire          hit    = phaseOk(phase, target, policy_r[`DLPC_BIT_SEARCH_TOLERANCE]);
    wire [DW-1:0] loB    = lowBound(guard, guardOff_r);
    wire [DW-1:0] hiB    = highBound(guard, guardOff_r);
    // slope decides which way a too-small phase moves the delay
    wire          phLow  = (phase < target);
    wire          stepUp = phLow ~^ slopePos;                          // [RL3]
    wire [DW-1:0] trkStep = {{(DW-2){1'b0}}, gain} + {{(DW-1){1'b0}}, 1'b1}; // [RL6]

    // ============================================================
    // input synchroniser for phase detector result
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            phaseSync1_r <= 5'h00;
            phaseSync2_r <= 5'h00;
        end else if (clkEn) begin
            phaseSync1_r <= phaseIn;
            phaseSync2_r <= phaseSync1_r;
        end
    end

    // ============================================================
    // register writes
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pdSetup_r    <= `DLPC_RST_PD_SETUP;
            dutySetup_r  <= `DLPC_RST_DUTY_SETUP;
            loopCtrl_r   <= `DLPC_RST_LOOP_CTRL;
            searchTgt_r  <= `DLPC_RST_SEARCH_TGT;
            delayUpper_r <= `DLPC_RST_DELAY_UPPER;
            policy_r     <= `DLPC_RST_POLICY;
        end else if (wrHit) begin
            case (regAddr)
                `DLPC_ADDR_PD_SETUP: begin
                    pdSetup_r <= regWrData & 8'h30;                    // [RL1]
                end
                `DLPC_ADDR_DUTY_SETUP: begin
                    dutySetup_r <= regWrData & 8'h80;                  // [RL2]
                end
                `DLPC_ADDR_LOOP_CTRL: begin
                    loopCtrl_r <= regWrData & 8'h7f;
                end
                `DLPC_ADDR_SEARCH_TGT: begin
                    searchTgt_r <= regWrData;
                end
                `DLPC_ADDR_DELAY_UPPER: begin
                    delayUpper_r <= regWrData;
                end
                `DLPC_ADDR_POLICY: begin
                    policy_r <= regWrData;
                end
                default: begin
                    pdSetup_r <= pdSetup_r;
                end
            endcase
        end
    end

    // ============================================================
    // shadow copy of bytes written at 0x20 to 0x27; shData feeds no readback
    always @(*) begin
        shAddr_r = regAddr[2:0];
    end

    dlpc_shadow_mem #(
        .AW (3),
        .DW (8)
    ) uShadow (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clkEn    (clkEn),
        .wrEn     (regWrEn & (regAddr[7:3] == 5'h04)),
        .wrAddr   (regAddr[2:0]),
        .wrData   (regWrData),
        .rdAddr   (shAddr_r),
        .rdData   (shData)
    );

    // ============================================================
    // search and track engine
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r      <= ST_IDLE;
            cur_r        <= {DW{1'b0}};
            lockedVal_r  <= {DW{1'b0}};
            locked_r     <= 1'b0;
            lostLock_r   <= 1'b0;
            dirUp_r      <= 1'b0;
            guardOff_r   <= 1'b0;
            secondPass_r <= 1'b0;
            settle_r     <= 8'h00;
            enPrev_r     <= 1'b0;
        end else if (clkEn) begin
            enPrev_r <= ctrlEn;
            if (!ctrlEn) begin
                state_r  <= ST_IDLE;
                cur_r    <= progDelay;                                 // [RL9]
                locked_r <= 1'b0;
            end else begin
                if (!enPrev_r) begin
                    lostLock_r <= 1'b0;                                // [RL23]
                end
                case (state_r)
                    ST_IDLE: begin
                        cur_r        <= progDelay;                     // [RL10]
                        dirUp_r      <= (searchDir == `DLPC_DIR_UP);   // [RL12]
                        secondPass_r <= 1'b0;
                        guardOff_r   <= 1'b0;
                        settle_r     <= `DLPC_SETTLE_CYCLES;
                        if (mode == `DLPC_MODE_TRACK_ONLY) begin
                            state_r <= ST_TRACK;                       // [RL4]
                        end else begin
                            state_r <= ST_SETTLE;                      // [RL4]
                        end
                    end
                    ST_SETTLE: begin
                        if (settle_r == 8'h00) begin
                            state_r <= ST_SEARCH;
                        end else begin
                            settle_r <= settle_r - 8'h01;
                        end
                    end
                    ST_SEARCH: begin
                        if (hit && cur_r >= loB && cur_r <= hiB) begin
                            locked_r    <= 1'b1;                       // [RL22]
                            lockedVal_r <= cur_r;
                            state_r     <= (mode == `DLPC_MODE_SRCH_ONLY) ? ST_HOLD : ST_TRACK; // [RL22]
                        end else if (dirUp_r && cur_r < hiB) begin
                            cur_r <= cur_r + {{(DW-1){1'b0}}, 1'b1};
                        end else if (!dirUp_r && cur_r > loB) begin
                            cur_r <= cur_r - {{(DW-1){1'b0}}, 1'b1};
                        end else if (searchDir == `DLPC_DIR_DOWN_UP && !secondPass_r) begin
                            secondPass_r <= 1'b1;                      // [RL12]
                            dirUp_r      <= 1'b1;
                            cur_r        <= progDelay;
                        end else if (!guardOff_r && guard != 5'h00) begin
                            guardOff_r   <= 1'b1;                      // [RL17]
                            secondPass_r <= 1'b0;
                            dirUp_r      <= (searchDir == `DLPC_DIR_UP);
                            cur_r        <= progDelay;
                        end else begin
                            state_r <= ST_FAIL;
                        end
                    end
                    // without retry or reset the engine parks on its last code
                    ST_FAIL: begin
                        if (policy_r[`DLPC_BIT_RST_ON_FAIL]) begin
                            state_r <= ST_IDLE;                        // [RL16]
                            cur_r   <= progDelay;
                        end else if (policy_r[`DLPC_BIT_RETRY]) begin
                            state_r <= ST_IDLE;                        // [RL15]
                        end else begin
                            state_r <= ST_FAIL;                        // [RL15] [RL16]
                        end
                    end
                    ST_TRACK: begin
                        if (hit) begin
                            locked_r    <= 1'b1;                       // [RL20]
                            lockedVal_r <= cur_r;
                        end else begin
                            if (locked_r) begin
                                lostLock_r <= 1'b1;                    // [RL18]
                            end
                            locked_r <= 1'b0;
                            if (stepUp && cur_r + trkStep <= `DLPC_DELAY_MAX) begin
                                cur_r <= cur_r + trkStep;              // [RL20]
                            end else if (!stepUp && cur_r >= trkStep) begin
                                cur_r <= cur_r - trkStep;
                            end
                        end
                    end
                    ST_HOLD: begin
                        state_r <= ST_HOLD;
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // outputs and readback
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            delayLine <= {DW{1'b0}};
            lockIrq   <= 1'b0;
            regRdData <= 8'h00;
        end else if (clkEn) begin
            // outputs are registered copies of engine state
            delayLine <= cur_r;
            lockIrq   <= lostLock_r;                                   // [RL21]
            if (regRdEn) begin
                case (regAddr)
                    `DLPC_ADDR_PD_SETUP:   regRdData <= pdSetup_r;
                    `DLPC_ADDR_DUTY_SETUP: regRdData <= dutySetup_r;
                    `DLPC_ADDR_LOOP_CTRL:  regRdData <= loopCtrl_r;
                    `DLPC_ADDR_SEARCH_TGT: begin
                        if (readback) begin
                            regRdData <= {(ctrlEn ? lockedVal_r[0] : progDelay[0]), searchTgt_r[6:0]}; // [RL5] [RL11]
                        end else begin
                            regRdData <= searchTgt_r;
                        end
                    end
                    `DLPC_ADDR_DELAY_UPPER: begin
                        if (readback) begin
                            regRdData <= ctrlEn ? lockedVal_r[8:1] : progDelay[8:1]; // [RL5] [RL11]
                        end else begin
                            regRdData <= delayUpper_r;
                        end
                    end
                    `DLPC_ADDR_POLICY:     regRdData <= policy_r;
                    `DLPC_ADDR_STATUS:     regRdData <= {6'h00, lostLock_r, locked_r}; // [RL18] [RL19]
                    default:               regRdData <= 8'h00;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: core/dlpc_regs.vh
// register offsets, field positions, reset values and timing counts of the delay line phase controller
`ifndef DLPC_REGS_VH
`define DLPC_REGS_VH
`define DLPC_ADDR_PD_SETUP      8'h24
`define DLPC_ADDR_DUTY_SETUP    8'h25
`define DLPC_ADDR_LOOP_CTRL     8'h26
`define DLPC_ADDR_SEARCH_TGT    8'h27
`define DLPC_ADDR_DELAY_UPPER   8'h28
`define DLPC_ADDR_POLICY        8'h29
`define DLPC_ADDR_STATUS        8'h2a
`define DLPC_RST_PD_SETUP       8'h00
`define DLPC_RST_DUTY_SETUP     8'h00
`define DLPC_RST_LOOP_CTRL      8'h42
`define DLPC_RST_SEARCH_TGT     8'h00
`define DLPC_RST_DELAY_UPPER    8'h00
`define DLPC_RST_POLICY         8'h0b
`define DLPC_BIT_PD_ENABLE      4
`define DLPC_BIT_CMP_BOOST      5
`define DLPC_BIT_DUTY_ENABLE    7
`define DLPC_BIT_SLOPE          6
`define DLPC_BIT_READBACK       3
`define DLPC_BIT_ENABLE         0
`define DLPC_BIT_DELAY_LSB      7
`define DLPC_BIT_SEARCH_TOLERANCE     7
`define DLPC_BIT_RETRY          6
`define DLPC_BIT_RST_ON_FAIL    5
`define DLPC_BIT_LOST_LOCK      1
`define DLPC_BIT_LOCKED         0
`define DLPC_MODE_SRCH_TRACK    2'h0
`define DLPC_MODE_SRCH_ONLY     2'h1
`define DLPC_MODE_TRACK_ONLY    2'h2
`define DLPC_DIR_DOWN           2'h0
`define DLPC_DIR_UP             2'h1
`define DLPC_DIR_DOWN_UP        2'h2
`define DLPC_DELAY_MAX          9'h1b0
`define DLPC_SETTLE_CYCLES      8'h10
`endif

// file: core/dlpc_shadow_mem.v
// small register-output memory holding the bytes written at 0x20 to 0x27
`timescale 1ns/1ps
`default_nettype none
module dlpc_shadow_mem #(
    parameter AW = 3,
    parameter DW = 8
) (
    input  wire          core_clk,
    input  wire          reset_n,
    input  wire          clkEn,
    input  wire          wrEn,
    input  wire [AW-1:0] wrAddr,
    input  wire [DW-1:0] wrData,
    input  wire [AW-1:0] rdAddr,
    output reg  [DW-1:0] rdData
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge core_clk) begin
        if (clkEn && wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= {DW{1'b0}};
        end else if (clkEn) begin
            rdData <= mem[rdAddr];
        end
    end
endmodule
`default_nettype wire

// file: testbench/dlpc_checker.sv
// port checker for the delay line phase controller
`timescale 1ns/1ps
`default_nettype none
module dlpc_checker #(
    parameter DW = 9
) (
    input wire logic          core_clk,
    input wire logic          reset_n,
    input wire logic          clkEn,
    input wire logic          regWrEn,
    input wire logic          regRdEn,
    input wire logic [7:0]    regAddr,
    input wire logic [7:0]    regWrData,
    input wire logic [7:0]    regRdData,
    input wire logic [4:0]    phaseIn,
    input wire logic [DW-1:0] delayLine,
    input wire logic          lockIrq
);
    // ============================================================
    // helper logic
    logic       rdTake;
    logic       wrLoop;
    logic [2:0] sinceLoopWr_r;
    assign rdTake = clkEn && regRdEn;
    assign wrLoop = clkEn && regWrEn && (regAddr == 8'h26);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sinceLoopWr_r <= 3'h0;
        end else if (wrLoop) begin
            sinceLoopWr_r <= 3'h0;
        end else if (sinceLoopWr_r != 3'h7) begin
            sinceLoopWr_r <= sinceLoopWr_r + 3'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // ============================================================
    // assertions
    pd_mask_a: assert property (rdTake && regAddr == 8'h24 |=> (regRdData & 8'hcf) == 8'h00)
        else $error("phase detector setup shows unused bits");
    duty_mask_a: assert property (rdTake && regAddr == 8'h25 |=> regRdData[6:0] == 7'h00)
        else $error("duty cycle setup shows unused bits");
    loop_mask_a: assert property (rdTake && regAddr == 8'h26 |=> regRdData[7] == 1'b0)
        else $error("loop control bit seven not zero");
    status_bits_a: assert property (rdTake && regAddr == 8'h2a |=> regRdData[7:2] == 6'h00)
        else $error("status upper bits not zero");
    read_hold_a: assert property (!rdTake |=> $stable(regRdData))
        else $error("read data changed without a read");
    freeze_all_a: assert property (!clkEn |=> $stable(delayLine) && $stable(lockIrq))
        else $error("state moved while clock enable low");
    delay_max_a: assert property (delayLine <= 432)
        else $error("delay line code above maximum");
    lost_sticky_a: assert property (lockIrq && sinceLoopWr_r >= 3'h6 |=> lockIrq)
        else $error("lost lock cleared without re-enable");
    irq_status_a: assert property (rdTake && regAddr == 8'h2a |=> regRdData[1] == lockIrq)
        else $error("interrupt high but lost flag reads zero");
    // ============================================================
    // covers
    cover property (rdTake && regAddr == 8'h2a ##1 regRdData[0]);
    cover property ($rose(lockIrq));
    cover property (!clkEn ##1 clkEn);
endmodule
bind dlpc_top dlpc_checker #(.DW(DW)) i_checker (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .clkEn     (clkEn),
    .regWrEn   (regWrEn),
    .regRdEn   (regRdEn),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .regRdData (regRdData),
    .phaseIn   (phaseIn),
    .delayLine (delayLine),
    .lockIrq   (lockIrq)
);
`default_nettype wire

// file: testbench/test_dlpc_top.sv
// self-checking bench for the delay line phase controller
`timescale 1ns/1ps
`default_nettype none
`include "dlpc_regs.vh"
module test_dlpc_top;
    logic        core_clk;
    logic        reset_n;
    logic        clkEn;
    logic        regWrEn;
    logic        regRdEn;
    logic [7:0]  regAddr;
    logic [7:0]  regWrData;
    logic [7:0]  regRdData;
    logic [4:0]  phaseIn;
    logic [8:0]  delayLine;
    logic        lockIrq;
    int          errors;
    int          n_compared;
    int          cycles;
    int          dly;
    logic [31:0] rnd;
    logic [1:0]  md;
    logic [1:0]  dr;
    logic [7:0]  rdv;
    logic [7:0]  stat;
    logic [7:0]  mdl [8'h24:8'h29];

    dlpc_top #(.DW(9)) i_dut (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .clkEn     (clkEn),
        .regWrEn   (regWrEn),
        .regRdEn   (regRdEn),
        .regAddr   (regAddr),
        .regWrData (regWrData),
        .regRdData (regRdData),
        .phaseIn   (phaseIn),
        .delayLine (delayLine),
        .lockIrq   (lockIrq)
    );

    // ============================================================
    // clock, timeout and shared tasks
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 10000) begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] expv, input string what);
        n_compared++;
        if (seen !== expv) begin
            errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, expv);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrEn <= 1'b0;
        if (a >= 8'h24 && a <= 8'h29) begin
            mdl[a] = d;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
    endtask
    // expected read value from the model
    function automatic logic [7:0] expRd(input logic [7:0] a);
        logic [7:0] m;
        m = (a >= 8'h24 && a <= 8'h29) ? mdl[a] : 8'h00;
        case (a)
            8'h24: expRd = m & 8'h30;
            8'h25: expRd = m & 8'h80;
            8'h26: expRd = m & 8'h7f;
            8'h2a: expRd = stat;
            default: expRd = m;
        endcase
    endfunction
    task automatic check_all();
        logic [7:0] d;
        for (int a = 8'h24; a <= 8'h2a; a++) begin
            rd(a[7:0], d);
            chk(d, expRd(a[7:0]), "register read");
        end
    endtask

    // ============================================================
    // main sequence
    initial begin
        core_clk  = 1'b0;
        reset_n   = 1'b0;
        clkEn     = 1'b1;
        regWrEn   = 1'b0;
        regRdEn   = 1'b0;
        regAddr   = 8'h00;
        regWrData = 8'h00;
        phaseIn   = 5'h00;
        errors    = 0;
        n_compared = 0;
        cycles    = 0;
        stat      = 8'h00;
        mdl[8'h24] = `DLPC_RST_PD_SETUP;
        mdl[8'h25] = `DLPC_RST_DUTY_SETUP;
        mdl[8'h26] = `DLPC_RST_LOOP_CTRL;
        mdl[8'h27] = `DLPC_RST_SEARCH_TGT;
        mdl[8'h28] = `DLPC_RST_DELAY_UPPER;
        mdl[8'h29] = `DLPC_RST_POLICY;
        rnd = $urandom(32'h1292);
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        check_all();
        rd(8'h30, rdv);
        chk(rdv, 8'h00, "unmapped read");
        wr(8'h24, 8'hff);
        wr(8'h25, 8'hff);
        wr(8'h2a, 8'hff);
        check_all();
        // manual delay with controller off, readback on
        for (int i = 0; i < 8; i++) begin
            rnd = $urandom;
            dly = (i == 0) ? 432 : $urandom_range(432, 0);
            md = (rnd[5:4] == 2'h3) ? 2'h0 : rnd[5:4];
            dr = (rnd[9:8] == 2'h3) ? 2'h2 : rnd[9:8];
            wr(8'h29, rnd[23:16]);
            wr(8'h26, {1'b0, rnd[6], md, 1'b1, rnd[2:1], 1'b0});
            wr(8'h27, {dly[0], dr, 5'(rnd[14:10] % 17)});
            wr(8'h28, dly[8:1]);
            repeat (3) @(posedge core_clk);
            #1;
            chk(delayLine, dly[8:0], "manual delay");
            check_all();
        end
        @(posedge core_clk);
        clkEn <= 1'b0;
        repeat (5) @(posedge core_clk);
        clkEn <= 1'b1;
        // search from midpoint, lock, track, lose lock
        wr(8'h29, 8'h8b);
        wr(8'h27, 8'h48);
        wr(8'h28, 8'h6c);
        phaseIn <= 5'h08;
        wr(8'h26, 8'h4b);
        repeat (100) @(posedge core_clk);
        rd(8'h2a, rdv);
        chk(rdv, 8'h01, "locked flag");
        rd(8'h28, rdv);
        chk(rdv, 8'h6c, "locked delay");
        @(posedge core_clk);
        phaseIn <= 5'h00;
        repeat (60) @(posedge core_clk);
        #1;
        chk(delayLine > 9'd216, 1'b1, "track direction");
        chk(lockIrq, 1'b1, "interrupt");
        @(posedge core_clk);
        clkEn <= 1'b0;
        @(posedge core_clk);
        #1;
        dly = delayLine;
        repeat (4) @(posedge core_clk);
        #1;
        chk(delayLine, dly[8:0], "frozen while tracking");
        @(posedge core_clk);
        clkEn <= 1'b1;
        @(posedge core_clk);
        phaseIn <= 5'h08;
        repeat (40) @(posedge core_clk);
        rd(8'h2a, rdv);
        chk(rdv[1], 1'b1, "lost flag held");
        wr(8'h26, 8'h4a);
        wr(8'h26, 8'h4b);
        repeat (100) @(posedge core_clk);
        rd(8'h2a, rdv);
        chk(rdv, 8'h01, "lost flag cleared");
        #1;
        chk(lockIrq, 1'b0, "interrupt cleared");
        // search only, upward from inside the upper guard band: fail, then retry within tolerance
        wr(8'h26, 8'h5a);
        wr(8'h29, 8'h8b);
        wr(8'h27, 8'h2a);
        wr(8'h28, 8'hd7);
        phaseIn <= 5'h0c;
        wr(8'h26, 8'h5b);
        repeat (40) @(posedge core_clk);
        #1;
        chk(delayLine, 9'd432, "guard released then stopped");
        rd(8'h2a, rdv);
        chk(rdv, 8'h00, "search failed");
        wr(8'h29, 8'h4b);
        repeat (40) @(posedge core_clk);
        rd(8'h2a, rdv);
        chk(rdv, 8'h01, "retry within two codes");
        rd(8'h28, rdv);
        chk(rdv, 8'hd7, "search only hold");
        end_sim();
    end
endmodule
`default_nettype wire
